// ### design/input_stage.sv
// Command/address input register with registered or buffered pass-through
module input_stage #(
  parameter int W = 20
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic         register_mode_sel,
  input  wire logic [W-1:0] in_bus,
  input  wire logic [W-1:0] idle_val,
  output logic [W-1:0]      out_bus
);
  logic [W-1:0] hold_q;
  always_ff @(posedge core_clk) begin
    if (!rstn) hold_q <= '1;
    else       hold_q <= in_bus;
  end
  // Registered mode adds one clock; buffered mode passes straight on
  assign out_bus = !rstn ? idle_val : (register_mode_sel ? hold_q : in_bus);
endmodule

// ### design/sdram_cmd_if.sv
// Registered 72-bit SDRAM module: command decode, clock gating and data masking
// Contract
// - Each edge's command comes from the row, column and write strobes plus the chip selects.
// - Clock enable high keeps the internal clock running; low stops it to the memory.
// - Clock enable low with all banks idle enters power-down or self refresh, else clock suspend.
// - Clock enable is synchronous except while in power-down or self refresh.
// - Input buffers, clock included, are shut off in power-down and self refresh.
// - Chip selects low enable the decoder; high, every command is ignored.
// - A write byte whose mask is high is not stored.
// - A mask high during a read turns that lane's output off two clocks later; data_oe here follows the mask three clocks later.
// - The bank address picks the bank of activate, read, write and precharge.
// - Activate captures all twelve address lines as the selected bank's row.
// - Read/write take the start column from low address bits; bit ten asks auto precharge.
// - Precharge with address bit ten high closes all banks, else only the selected one.
// - Load mode register writes the address lines into the mode register.
// - Register enable high delays control and address by one clock; low passes them through.
// - Bursts are 1, 2, 4, 8 or a full page, and burst terminate is supported.
module sdram_cmd_if
  import sdram_cmd_pkg::*;
#(
  parameter int ROWS_LOG = 6,
  parameter int COL_W    = 9
) (
  input  wire logic                              core_clk,
  input  wire logic                              rstn,
  input  wire logic                              register_mode_sel,
  input  wire logic                              clock_gate_in,
  input  wire logic                              select_lo_n,
  input  wire logic                              select_hi_n,
  input  wire logic                              ras_n,
  input  wire logic                              cas_n,
  input  wire logic                              we_n,
  input  wire logic                              bank_sel_0,
  input  wire logic                              bank_sel_1,
  input  wire logic [sdram_cmd_pkg::ADDR_W-1:0]  addr_bus,
  input  wire logic [sdram_cmd_pkg::LANES-1:0]   byte_mask,
  input  wire logic [sdram_cmd_pkg::DATA_W-1:0]  data_bus_in,
  input  wire logic [sdram_cmd_pkg::CHECK_W-1:0] check_bits_in,
  output logic [sdram_cmd_pkg::DATA_W-1:0]       data_bus_out,
  output logic [sdram_cmd_pkg::CHECK_W-1:0]      check_bits_out,
  output logic [sdram_cmd_pkg::LANES-1:0]        data_oe,
  output logic                                   clock_active,
  output logic                                   in_buffers_on,
  output logic                                   in_power_down,
  output logic                                   in_self_refresh,
  output logic                                   in_clock_suspend,
  output logic [sdram_cmd_pkg::NUM_BANKS-1:0]    bank_open,
  output logic [sdram_cmd_pkg::MODE_W-1:0]       mode_reg,
  output logic                                   auto_prech_pend,
  output logic                                   burst_busy
);
  import sdram_cmd_pkg::*;
  localparam int SW = 3 + 2 + BANK_W + ADDR_W + LANES + 1;
  localparam int MW = ROWS_LOG + COL_W_MAX;
  localparam logic [SW-1:0] SW_IDLE = {{(3 + 2){1'b1}}, {(SW - 5){1'b0}}};

  // Command/address stage (registered or buffered)
  logic [SW-1:0] stg;
  input_stage #(.W(SW)) u_stage (
    .core_clk          (core_clk),
    .rstn              (rstn),
    .register_mode_sel (register_mode_sel),
    .in_bus            ({ras_n, cas_n, we_n, select_lo_n, select_hi_n, bank_sel_1, bank_sel_0,
                         addr_bus, byte_mask, clock_gate_in}),
    .idle_val          (SW_IDLE),
    .out_bus           (stg)
  );

  wire                 s_ras   = stg[SW-1];
  wire                 s_cas   = stg[SW-2];
  wire                 s_we    = stg[SW-3];
  wire                 s_sel_lo = stg[SW-4];
  wire                 s_sel_hi = stg[SW-5];
  wire [BANK_W-1:0]    s_bank  = stg[SW-6 -: BANK_W];
  wire [ADDR_W-1:0]    s_addr  = stg[LANES+ADDR_W:LANES+1];
  wire [LANES-1:0]     s_mask  = stg[LANES:1];
  wire                 s_cke   = stg[0];

  mode_t st_q;
  mode_t st_d;
  logic  cke_prev_q;
  wire   low_power = (st_q == ST_POWERDOWN) || (st_q == ST_SELFREF);
  // In low power the enable is looked at directly, bypassing the stage
  wire   cke_eff   = low_power ? clock_gate_in : s_cke;
  wire   clk_run   = cke_prev_q && cke_eff;
  wire   selected  = !s_sel_lo && !s_sel_hi;
  cmd_t  cmd;
  assign cmd = (selected && clk_run && !low_power) ? decode_cmd(s_ras, s_cas, s_we)
                                                   : CMD_NOP;

  logic [NUM_BANKS-1:0] open_q;
  logic [ADDR_W-1:0]    row_q [NUM_BANKS];
  logic [MODE_W-1:0]    mode_q;
  logic [10:0]          left_q;
  logic [COL_W_MAX-1:0] col_q;
  logic [BANK_W-1:0]    bb_q;
  logic                 ap_q;
  logic [LANES-1:0]     rmask_q1;
  logic [LANES-1:0]     rmask_q2;
  logic [LANES-1:0]     oe_q;
  logic                 rd_pend_q;
  logic                 rd_valid_q;

  wire burst_on   = (st_q == ST_READ) || (st_q == ST_WRITE);
  wire all_idle   = (open_q == '0) && !burst_on;
  wire [10:0] blen = burst_len(mode_q[MODE_BL_LSB +: MODE_BL_W]);
  wire [COL_W_MAX-1:0] col_mask = COL_W_MAX'((11'h001 << COL_W) - 11'h001);
  wire [COL_W_MAX-1:0] start_col = s_addr[COL_W_MAX-1:0] & col_mask;
  wire go_rd = (cmd == CMD_READ)  && open_q[s_bank];
  wire go_wr = (cmd == CMD_WRITE) && open_q[s_bank];
  wire last_beat = burst_on && clk_run && (left_q == 11'h001);
  wire burst_end = last_beat || (cmd == CMD_TERM);

  // Array, one slot per column of each row slice
  logic [BUS_W-1:0] mem [2**MW];
  wire [MW-1:0] acc_addr = {row_q[bb_q][ROWS_LOG-1:0], col_q};

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (!cke_eff && all_idle && cke_prev_q) begin
          st_d = (selected && decode_cmd(s_ras, s_cas, s_we) == CMD_REFRESH) ? ST_SELFREF
                                                                               : ST_POWERDOWN;
        end else if (go_rd) begin
          st_d = ST_READ;
        end else if (go_wr) begin
          st_d = ST_WRITE;
        end
      end
      ST_READ, ST_WRITE: begin
        if (go_rd)          st_d = ST_READ;
        else if (go_wr)     st_d = ST_WRITE;
        else if (burst_end) st_d = ST_IDLE;
      end
      ST_POWERDOWN, ST_SELFREF: begin
        if (clock_gate_in) st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_q       <= ST_IDLE;
      cke_prev_q <= 1'b1;
      mode_q     <= MODE_RESET;
    end else begin
      st_q       <= st_d;
      cke_prev_q <= cke_eff;
      if (cmd == CMD_LMR && all_idle) mode_q <= s_addr[MODE_W-1:0];
    end
  end

  // Bank rows and open/close tracking
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      open_q <= '0;
      for (int i = 0; i < NUM_BANKS; i++) row_q[i] <= '0;
    end else begin
      // Auto precharge first, so an activate to the same bank in the same cycle keeps it
      if (burst_end && ap_q && !go_rd && !go_wr) begin
        open_q[bb_q] <= 1'b0;
      end
      if (cmd == CMD_ACTIVE) begin
        open_q[s_bank] <= 1'b1;
        row_q[s_bank]  <= s_addr;
      end else if (cmd == CMD_PRECH) begin
        if (s_addr[AP_BIT]) open_q <= '0;
        else                open_q[s_bank] <= 1'b0;
      end
    end
  end

  // Burst address and count; a stopped clock freezes the burst
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      left_q <= '0;
      col_q  <= '0;
      bb_q   <= '0;
      ap_q   <= 1'b0;
    end else if (go_rd || go_wr) begin
      left_q <= blen;
      col_q  <= start_col;
      bb_q   <= s_bank;
      ap_q   <= s_addr[AP_BIT];
    end else if (burst_on && clk_run) begin
      left_q <= left_q - 11'h001;
      col_q  <= (col_q + 1'b1) & col_mask;
      if (burst_end) ap_q <= 1'b0;
    end
  end

  wire wr_beat = (st_q == ST_WRITE) && clk_run;
  wire rd_beat = (st_q == ST_READ) && clk_run;
  wire [BUS_W-1:0] wdata = {check_bits_in, data_bus_in};
  logic [BUS_W-1:0] rd_word;

  // Write strobes per lane
  always_ff @(posedge core_clk) begin
    for (int l = 0; l < LANES; l++) begin
      if (wr_beat && !s_mask[l])
        mem[acc_addr][l*8 +: 8] <= wdata[l*8 +: 8];
    end
    if (wr_beat && !s_mask[LANES-1])
      mem[acc_addr][BUS_W-1 -: CHECK_W] <= wdata[BUS_W-1 -: CHECK_W];
  end

  // Check-bit lane: byte 8 of the stored word is the check byte under mask 7
  assign rd_word = mem[acc_addr];

  // Read data path through the FIFO
  logic             fifo_ok;
  logic             fo_valid;
  logic [BUS_W-1:0] fo_data;
  word_fifo #(.WIDTH(BUS_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .in_valid  (rd_beat),
    .in_ready  (fifo_ok),
    .in_data   (rd_word),
    .out_valid (fo_valid),
    .out_ready (rd_valid_q),
    .out_data  (fo_data)
  );

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rd_pend_q      <= 1'b0;
      rd_valid_q     <= 1'b0;
      rmask_q1       <= '1;
      rmask_q2       <= '1;
      oe_q           <= '0;
      data_bus_out   <= '0;
      check_bits_out <= '0;
    end else begin
      // Beat data leaves the FIFO two clocks after its beat, in step with its mask
      rd_pend_q  <= rd_beat && fifo_ok;
      rd_valid_q <= rd_pend_q;
      rmask_q1   <= (rd_beat && fifo_ok) ? s_mask : '1;
      rmask_q2   <= rmask_q1;
      oe_q       <= rd_valid_q ? ~rmask_q2 : '0;
      if (rd_valid_q) begin
        data_bus_out   <= fo_data[DATA_W-1:0];
        check_bits_out <= fo_data[BUS_W-1:DATA_W];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      clock_active     <= 1'b1;
      in_buffers_on    <= 1'b1;
      in_power_down    <= 1'b0;
      in_self_refresh  <= 1'b0;
      in_clock_suspend <= 1'b0;
      bank_open        <= '0;
      mode_reg         <= MODE_RESET;
      auto_prech_pend  <= 1'b0;
      burst_busy       <= 1'b0;
    end else begin
      clock_active     <= cke_eff && !(st_d == ST_POWERDOWN || st_d == ST_SELFREF);
      in_buffers_on    <= !(st_d == ST_POWERDOWN || st_d == ST_SELFREF);
      in_power_down    <= st_d == ST_POWERDOWN;
      in_self_refresh  <= st_d == ST_SELFREF;
      in_clock_suspend <= burst_on && !cke_eff;
      bank_open        <= open_q;
      mode_reg         <= mode_q;
      auto_prech_pend  <= ap_q;
      burst_busy       <= burst_on;
    end
  end
  assign data_oe = oe_q;

  property p_cs_mask;
    @(posedge core_clk) disable iff (!rstn)
      (s_sel_lo || s_sel_hi) && !low_power && !burst_on |=> $stable(open_q) && $stable(mode_q);
  endproperty
  a_cs_mask: assert property (p_cs_mask) else $error("deselected command acted");

  property p_act_row;
    @(posedge core_clk) disable iff (!rstn)
      cmd == CMD_ACTIVE |=> open_q[$past(s_bank)] && row_q[$past(s_bank)] == $past(s_addr);
  endproperty
  a_act_row: assert property (p_act_row) else $error("activate did not capture row");

  property p_prech_all;
    @(posedge core_clk) disable iff (!rstn)
      cmd == CMD_PRECH && s_addr[AP_BIT] |=> open_q == '0;
  endproperty
  a_prech_all: assert property (p_prech_all) else $error("precharge all left a bank open");

  property p_lmr;
    @(posedge core_clk) disable iff (!rstn)
      cmd == CMD_LMR && all_idle |=> mode_q == $past(s_addr);
  endproperty
  a_lmr: assert property (p_lmr) else $error("mode register not loaded");

  property p_rmask_lat;
    @(posedge core_clk) disable iff (!rstn)
      rd_beat && fifo_ok |-> ##3 data_oe == ~$past(s_mask, 3);
  endproperty
  a_rmask_lat: assert property (p_rmask_lat) else $error("read mask latency wrong");

  property p_pd_bufs;
    @(posedge core_clk) disable iff (!rstn)
      low_power |-> !in_buffers_on || $past(!low_power);
  endproperty
  a_pd_bufs: assert property (p_pd_bufs) else $error("buffers on in power-down");

  property p_pd_entry;
    @(posedge core_clk) disable iff (!rstn)
      st_q == ST_IDLE && all_idle && cke_prev_q && !cke_eff |=> low_power;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("idle clock stop missed power-down");

  property p_suspend;
    @(posedge core_clk) disable iff (!rstn)
      burst_on && !cke_eff && !go_rd && !go_wr && cmd != CMD_TERM |=> $stable(left_q);
  endproperty
  a_suspend: assert property (p_suspend) else $error("burst advanced during suspend");

  property p_burst_len;
    @(posedge core_clk) disable iff (!rstn)
      go_rd || go_wr |=> left_q == $past(blen);
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst length not loaded");
endmodule

// ### design/sdram_cmd_pkg.sv
// Shared constants and types for the registered SDRAM module command interface
package sdram_cmd_pkg;
  localparam int ADDR_W      = 12;
  localparam int BANK_W      = 2;
  localparam int NUM_BANKS   = 4;
  localparam int LANES       = 8;
  localparam int LANE_W      = 9;
  localparam int DATA_W      = 64;
  localparam int CHECK_W     = 8;
  localparam int BUS_W       = DATA_W + CHECK_W;
  localparam int COL_W_MAX   = 10;
  localparam int AP_BIT      = 10;
  localparam int MODE_W      = 12;
  localparam int READ_MASK_LAT = 2;
  localparam int FIFO_DEPTH  = 8;
  localparam logic [MODE_W-1:0] MODE_RESET = 12'h000;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BL_W   = 3;
  localparam int MODE_CL_LSB = 4;
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [10:0] PAGE_LEN = 11'h400;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE, CMD_TERM, CMD_PRECH, CMD_REFRESH, CMD_LMR
  } cmd_t;

  typedef enum {ST_IDLE, ST_READ, ST_WRITE, ST_POWERDOWN, ST_SELFREF} mode_t;

  // Row/column/write strobes (active low) to a command code
  function automatic cmd_t decode_cmd(input logic ras_n, input logic cas_n, input logic we_n);
    case ({ras_n, cas_n, we_n})
      3'h3: decode_cmd = CMD_ACTIVE;
      3'h5: decode_cmd = CMD_READ;
      3'h4: decode_cmd = CMD_WRITE;
      3'h6: decode_cmd = CMD_TERM;
      3'h2: decode_cmd = CMD_PRECH;
      3'h1: decode_cmd = CMD_REFRESH;
      3'h0: decode_cmd = CMD_LMR;
      default: decode_cmd = CMD_NOP;
    endcase
  endfunction

  function automatic logic [10:0] burst_len(input logic [2:0] code);
    case (code)
      BL_1:    burst_len = 11'h001;
      BL_2:    burst_len = 11'h002;
      BL_4:    burst_len = 11'h004;
      BL_8:    burst_len = 11'h008;
      BL_PAGE: burst_len = PAGE_LEN;
      default: burst_len = 11'h001;
    endcase
  endfunction
endpackage

// ### design/word_fifo.sv
// Parameterised valid/ready FIFO for data words
module word_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = int'(cnt_q) != DEPTH;
  assign out_valid = cnt_q != '0;
  assign out_data  = mem[rd_q];

  always_ff @(posedge core_clk) begin
    if (push) mem[wr_q] <= in_data;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (int'(wr_q) == DEPTH-1) ? '0 : wr_q + 1'b1;
      if (pop)  rd_q <= (int'(rd_q) == DEPTH-1) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// ### dv/host_model.sv
// Behavioural host controller driving the SDRAM command, mask and write-data lines
module host_model (
  input  wire logic                              core_clk,
  output logic                                   clock_gate_in,
  output logic                                   select_lo_n,
  output logic                                   select_hi_n,
  output logic                                   ras_n,
  output logic                                   cas_n,
  output logic                                   we_n,
  output logic                                   bank_sel_0,
  output logic                                   bank_sel_1,
  output logic [sdram_cmd_pkg::ADDR_W-1:0]       addr_bus,
  output logic [sdram_cmd_pkg::LANES-1:0]        byte_mask,
  output logic [sdram_cmd_pkg::DATA_W-1:0]       data_bus_in,
  output logic [sdram_cmd_pkg::CHECK_W-1:0]      check_bits_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import sdram_cmd_pkg::*;

  initial begin
    clock_gate_in = 1'b1;
    {select_lo_n, select_hi_n} = 2'h3;
    {ras_n, cas_n, we_n} = 3'h7;
    {bank_sel_1, bank_sel_0} = 2'h0;
    addr_bus = 12'h000;
    byte_mask = 8'h00;
    data_bus_in = 64'h0;
    check_bits_in = 8'h00;
  end

  // One full bus cycle, launched just after the edge and held to the next
  task automatic drive(input logic ke, input logic sel_n, input logic [2:0] rcw,
                       input logic [1:0] ba, input logic [11:0] a, input logic [7:0] m,
                       input logic [63:0] d, input logic [7:0] c);
    @(posedge core_clk);
    #1;
    clock_gate_in = ke;
    {select_lo_n, select_hi_n} = {sel_n, sel_n};
    {ras_n, cas_n, we_n} = rcw;
    {bank_sel_1, bank_sel_0} = ba;
    addr_bus = a;
    byte_mask = m;
    data_bus_in = d;
    check_bits_in = c;
  endtask

  // Command without data: the data lines flip so no stale value lingers
  task automatic cmd(input logic ke, input logic sel_n, input logic [2:0] rcw,
                     input logic [1:0] ba, input logic [11:0] a);
    drive(ke, sel_n, rcw, ba, a, 8'h00, ~data_bus_in, ~check_bits_in);
  endtask
endmodule

// ### dv/tb_sdram_cmd_if.sv
// Self-checking bench for the registered SDRAM module command interface
module tb_sdram_cmd_if;
  timeunit 1ns;
  timeprecision 1ps;
  import sdram_cmd_pkg::*;

  localparam logic [2:0] ACT = 3'h3, RD = 3'h5, WR = 3'h4, TRM = 3'h6;
  localparam logic [2:0] PRE = 3'h2, REF = 3'h1, LMR = 3'h0, NOP = 3'h7;

  typedef struct {
    logic        sel_n;
    logic [2:0]  rcw;
    logic [1:0]  ba;
    logic [11:0] a;
    logic [3:0]  banks;
    logic [11:0] mode;
  } row_t;

  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        register_mode_sel = 1'b0;
  logic        clock_gate_in, select_lo_n, select_hi_n, ras_n, cas_n, we_n;
  logic        bank_sel_0, bank_sel_1, clock_active, in_buffers_on, in_power_down;
  logic        in_self_refresh, in_clock_suspend, auto_prech_pend, burst_busy;
  logic [11:0] addr_bus, mode_reg;
  logic [7:0]  byte_mask, check_bits_in, check_bits_out, data_oe, seen_oe, seen_c;
  logic [63:0] data_bus_in, data_bus_out, seen_d;
  logic [3:0]  bank_open;
  int          fail_count = 0;
  int          compares = 0;
  int          cycles = 0;
  int          nb, nr, n;

  row_t rows [8] = '{
    '{1'b0, ACT, 2'h0, 12'h005, 4'h1, 12'h000},
    '{1'b0, ACT, 2'h2, 12'h0A5, 4'h5, 12'h000},
    '{1'b1, ACT, 2'h3, 12'h005, 4'h5, 12'h000},
    '{1'b0, ACT, 2'h3, 12'hFFF, 4'hD, 12'h000},
    '{1'b0, PRE, 2'h2, 12'h000, 4'h9, 12'h000},
    '{1'b0, LMR, 2'h0, 12'h023, 4'h9, 12'h000},
    '{1'b0, PRE, 2'h1, 12'h400, 4'h0, 12'h000},
    '{1'b0, LMR, 2'h0, 12'h023, 4'h0, 12'h023}
  };

  always #5 core_clk = ~core_clk;

  host_model p (.core_clk, .clock_gate_in, .select_lo_n, .select_hi_n, .ras_n, .cas_n,
    .we_n, .bank_sel_0, .bank_sel_1, .addr_bus, .byte_mask, .data_bus_in, .check_bits_in);

  sdram_cmd_if dut (.core_clk, .rstn, .register_mode_sel, .clock_gate_in, .select_lo_n,
    .select_hi_n, .ras_n, .cas_n, .we_n, .bank_sel_0, .bank_sel_1, .addr_bus, .byte_mask,
    .data_bus_in, .check_bits_in, .data_bus_out, .check_bits_out, .data_oe, .clock_active,
    .in_buffers_on, .in_power_down, .in_self_refresh, .in_clock_suspend, .bank_open,
    .mode_reg, .auto_prech_pend, .burst_busy);

  task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic idle(input int k);
    repeat (k) p.cmd(1'b1, 1'b0, NOP, 2'h0, 12'h000);
  endtask

  task automatic wr(input logic [7:0] m, input logic [63:0] d, input logic [7:0] c);
    p.cmd(1'b1, 1'b0, WR, 2'h1, 12'h004);
    p.drive(1'b1, 1'b0, NOP, 2'h0, 12'h000, m, d, c);
    idle(2);
  endtask

  // Read column 4 of bank 1 with a beat mask and catch the first driven beat
  task automatic rd(input logic [7:0] m);
    p.cmd(1'b1, 1'b0, RD, 2'h1, 12'h004);
    p.drive(1'b1, 1'b0, NOP, 2'h0, 12'h000, m, 64'h0, 8'h00);
    seen_oe = 8'h00;
    for (int i = 0; i < 12 && seen_oe === 8'h00; i++) begin
      idle(1);
      seen_oe = data_oe;
      seen_d = data_bus_out;
      seen_c = check_bits_out;
    end
    idle(4);
  endtask

  // Cycles from an activate until its bank shows open
  task automatic open_lat(output int k);
    p.cmd(1'b1, 1'b0, PRE, 2'h0, 12'h400);
    idle(3);
    p.cmd(1'b1, 1'b0, ACT, 2'h0, 12'h001);
    k = 0;
    while (bank_open[0] !== 1'b1 && k < 10) begin
      idle(1);
      k++;
    end
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    repeat (3) @(posedge core_clk);
    #1 rstn = 1'b1;
    idle(1);
    chk("clock_active", 1, clock_active);
    chk("in_buffers_on", 1, in_buffers_on);
    chk("reset bank_open", 0, bank_open);
    chk("reset data_oe", 0, data_oe);
    foreach (rows[i]) begin
      p.cmd(1'b1, rows[i].sel_n, rows[i].rcw, rows[i].ba, rows[i].a);
      idle(3);
      chk("bank_open", rows[i].banks, bank_open);
      chk("mode_reg", rows[i].mode, mode_reg);
    end
    // Single-beat bursts; row opened before any access
    p.cmd(1'b1, 1'b0, LMR, 2'h0, 12'h000);
    p.cmd(1'b1, 1'b0, ACT, 2'h1, 12'h005);
    idle(1);
    wr(8'h00, 64'h1122334455667788, 8'hA5);
    wr(8'h01, 64'h99AABBCCDDEEFF00, 8'h3C);
    rd(8'h00);
    chk("read data", 64'h99AABBCCDDEEFF88, seen_d);
    chk("read check", 8'h3C, seen_c);
    chk("read oe", 8'hFF, seen_oe);
    rd(8'h08);
    chk("masked oe", 8'hF7, seen_oe);
    for (int c = 0; c < 4; c++) begin
      p.cmd(1'b1, 1'b0, PRE, 2'h0, 12'h400);
      idle(2);
      p.cmd(1'b1, 1'b0, LMR, 2'h0, 12'(c));
      p.cmd(1'b1, 1'b0, ACT, 2'h1, 12'h005);
      p.cmd(1'b1, 1'b0, RD, 2'h1, (c == 3) ? 12'h400 : 12'h000);
      n = 0;
      repeat (2) begin
        idle(1);
        n += (data_oe !== 8'h00);
      end
      chk("auto_prech_pend", c == 3, auto_prech_pend);
      repeat (22) begin
        idle(1);
        n += (data_oe !== 8'h00);
      end
      chk("burst beats", 1 << c, n);
    end
    chk("auto precharge", 0, bank_open);
    p.cmd(1'b1, 1'b0, LMR, 2'h0, 12'h007);
    p.cmd(1'b1, 1'b0, ACT, 2'h1, 12'h005);
    p.cmd(1'b1, 1'b0, RD, 2'h1, 12'h000);
    idle(3);
    repeat (3) p.cmd(1'b0, 1'b0, NOP, 2'h0, 12'h000);
    chk("in_clock_suspend", 1, in_clock_suspend);
    chk("suspend not down", 0, in_power_down);
    idle(2);
    chk("page busy", 1, burst_busy);
    p.cmd(1'b1, 1'b0, TRM, 2'h0, 12'h000);
    idle(4);
    chk("terminated", 0, burst_busy);
    p.cmd(1'b1, 1'b0, PRE, 2'h0, 12'h400);
    idle(3);
    p.cmd(1'b0, 1'b0, NOP, 2'h0, 12'h000);
    repeat (2) p.cmd(1'b0, 1'b0, ACT, 2'h0, 12'h001);
    chk("in_power_down", 1, in_power_down);
    chk("clock stopped", 0, clock_active);
    chk("buffers off", 0, in_buffers_on);
    idle(4);
    chk("down exit", 0, in_power_down);
    chk("clock back", 1, clock_active);
    chk("ignored while down", 0, bank_open);
    p.cmd(1'b0, 1'b0, REF, 2'h0, 12'h000);
    repeat (2) p.cmd(1'b0, 1'b0, NOP, 2'h0, 12'h000);
    chk("in_self_refresh", 1, in_self_refresh);
    idle(4);
    chk("refresh exit", 0, in_self_refresh);
    open_lat(nb);
    register_mode_sel = 1'b1;
    open_lat(nr);
    chk("registered delay", nb + 1, nr);
    final_report();
  end
endmodule
